// [rtl/reset_sequencer_error_pin.sv]
/*
  reset sequencing outputs, boot pin capture and safety error pin.
  assumes synchronous inputs, and that the board keeps its own reset widths.
*/
//
// Contract
// - por low drives all status outputs low
// - mcu status releases 6120 periods after por
// - main status releases 9195 periods after por
// - sw mcu warm reset: mcu status 966
// - sw resets: main status low 4040 periods
// - main por output rises 1840 ns late
// - main por output low at least 1200 ns
// - error pin active 50 periods after error
// - non-pwm error pulse low at least preload periods, until cleared
// - pwm period is high plus low preloads
// - pwm freezes level on error until cleared
module reset_sequencer_error_pin (
  input  wire logic                            clock,
  input  wire logic                            rst_n,
  input  wire logic                            power_on_reset_in_n,
  input  wire logic                            mcu_warm_reset_in_n,
  input  wire logic                            sw_mcu_domain_warm_reset,
  input  wire logic                            sw_main_power_on_reset,
  input  wire logic                            sw_main_domain_warm_reset,
  input  wire logic [rst_seq_pkg::BOOT_W-1:0]  boot_config_pins,
  input  wire logic                            error_event,
  input  wire logic                            error_clear,
  input  wire logic                            pwm_mode_en,
  input  wire logic [rst_seq_pkg::CNT_W-1:0]   pin_counter_preload,
  input  wire logic [rst_seq_pkg::CNT_W-1:0]   pwm_high_preload,
  input  wire logic [rst_seq_pkg::CNT_W-1:0]   pwm_low_preload,
  output logic                                 mcu_domain_reset_status_n,
  output logic                                 main_domain_reset_status_n,
  output logic                                 main_por_out_n,
  output logic [rst_seq_pkg::BOOT_W-1:0]       boot_config_latched,
  output logic                                 safety_error_out_n,
  output logic                                 error_active
);
  // ----------------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------------
  // one countdown per output; zero means released
  logic [rst_seq_pkg::CNT_W-1:0] mcu_cnt_q, mcu_cnt_d;
  logic [rst_seq_pkg::CNT_W-1:0] main_cnt_q, main_cnt_d;
  logic [rst_seq_pkg::CNT_W-1:0] por_cnt_q, por_cnt_d;
  logic [rst_seq_pkg::BOOT_W-1:0] boot_q, boot_d;

  function automatic logic [rst_seq_pkg::CNT_W-1:0] hold_max(
    input logic [rst_seq_pkg::CNT_W-1:0] cur,
    input logic [rst_seq_pkg::CNT_W-1:0] want);
    hold_max = (cur > want) ? cur : want;
  endfunction

  function automatic logic [rst_seq_pkg::CNT_W-1:0] dec(
    input logic [rst_seq_pkg::CNT_W-1:0] cur);
    dec = (cur == rst_seq_pkg::CNT_ZERO) ? cur : cur - rst_seq_pkg::CNT_ONE;
  endfunction

  localparam logic [rst_seq_pkg::CNT_W-1:0] MCU_POR  =
    rst_seq_pkg::CNT_W'(rst_seq_pkg::MCU_STAT_PERIODS);
  localparam logic [rst_seq_pkg::CNT_W-1:0] MAIN_POR =
    rst_seq_pkg::CNT_W'(rst_seq_pkg::MAIN_STAT_PERIODS);
  localparam logic [rst_seq_pkg::CNT_W-1:0] MCU_SW   =
    rst_seq_pkg::CNT_W'(rst_seq_pkg::SW_MCU_PERIODS);
  localparam logic [rst_seq_pkg::CNT_W-1:0] MAIN_SW  =
    rst_seq_pkg::CNT_W'(rst_seq_pkg::SW_MAIN_PERIODS);
  localparam logic [rst_seq_pkg::CNT_W-1:0] POR_DLY  =
    rst_seq_pkg::CNT_W'(rst_seq_pkg::POR_OUT_DELAY_CYC);
  localparam logic [rst_seq_pkg::CNT_W-1:0] POR_WID  =
    rst_seq_pkg::CNT_W'(rst_seq_pkg::POR_OUT_WIDTH_CYC);

  wire por_in    = !power_on_reset_in_n;
  wire mcu_warm  = sw_mcu_domain_warm_reset | !mcu_warm_reset_in_n;
  wire main_sw   = mcu_warm | sw_main_power_on_reset | sw_main_domain_warm_reset;
  wire por_rise  = (por_cnt_q == rst_seq_pkg::CNT_ONE) && !por_in;

  // counters reload while the source is held and start on its release
  always_comb begin
    mcu_cnt_d  = dec(mcu_cnt_q);
    main_cnt_d = dec(main_cnt_q);
    por_cnt_d  = dec(por_cnt_q);
    boot_d     = boot_q;
    if (por_in) begin
      mcu_cnt_d  = MCU_POR;
      main_cnt_d = MAIN_POR;
      por_cnt_d  = POR_DLY;
    end else begin
      if (mcu_warm) begin
        mcu_cnt_d = hold_max(mcu_cnt_q, MCU_SW);
      end
      if (main_sw) begin
        main_cnt_d = hold_max(main_cnt_q, MAIN_SW);
      end
      if (sw_main_power_on_reset) begin
        por_cnt_d = hold_max(por_cnt_q, POR_WID);
      end
    end
    // capture on the rising edge of the main por output
    if (por_rise) begin
      boot_d = boot_config_pins;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mcu_cnt_q  <= MCU_POR;
      main_cnt_q <= MAIN_POR;
      por_cnt_q  <= POR_DLY;
      boot_q     <= rst_seq_pkg::BOOT_RESET;
    end else begin
      mcu_cnt_q  <= mcu_cnt_d;
      main_cnt_q <= main_cnt_d;
      por_cnt_q  <= por_cnt_d;
      boot_q     <= boot_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // the por input gates outputs directly so assertion has zero delay
  assign mcu_domain_reset_status_n  = !por_in && (mcu_cnt_q == rst_seq_pkg::CNT_ZERO);
  assign main_domain_reset_status_n = !por_in && (main_cnt_q == rst_seq_pkg::CNT_ZERO);
  assign main_por_out_n             = !por_in && (por_cnt_q == rst_seq_pkg::CNT_ZERO);
  assign boot_config_latched        = boot_q;

  // ----------------------------------------------------------------------
  // error pin
  // ----------------------------------------------------------------------
  err_pin_if epin ();
  assign epin.err_event     = error_event;
  assign epin.err_clear     = error_clear;
  assign epin.pwm_en        = pwm_mode_en;
  assign epin.pulse_preload = pin_counter_preload;
  assign epin.high_preload  = pwm_high_preload;
  assign epin.low_preload   = pwm_low_preload;

  err_pin_unit u_err (
    .clock (clock),
    .rst_n (rst_n),
    .bus   (epin.pin)
  );

  assign safety_error_out_n = epin.pin_n;
  assign error_active       = epin.err_active;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_POR_ASSERT: assert property (@(posedge clock) disable iff (!rst_n)
    por_in |-> (!mcu_domain_reset_status_n && !main_domain_reset_status_n && !main_por_out_n))
    else $error("outputs not low during power-on reset");
  AST_MCU_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    ($fell(por_in)) |=> (mcu_cnt_q == MCU_POR - rst_seq_pkg::CNT_ONE))
    else $error("mcu status counter not loaded");
  AST_MAIN_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    ($fell(por_in)) |=> (main_cnt_q == MAIN_POR - rst_seq_pkg::CNT_ONE))
    else $error("main status counter not loaded");
  AST_SW_MCU: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_mcu_domain_warm_reset && !por_in) |=> (mcu_cnt_q >= MCU_SW - rst_seq_pkg::CNT_ONE))
    else $error("mcu warm reset too short");
  AST_SW_MAIN: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_main_domain_warm_reset && !por_in) |=> !main_domain_reset_status_n [*8])
    else $error("main warm reset too short");
  AST_POR_DELAY: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(por_in) |-> !main_por_out_n [*8])
    else $error("main por output released too early");
  AST_POR_WIDTH: assert property (@(posedge clock) disable iff (!rst_n)
    (sw_main_power_on_reset && !por_in) |=> (por_cnt_q >= POR_WID - rst_seq_pkg::CNT_ONE))
    else $error("main por output pulse too short");
  AST_BOOT_CAP: assert property (@(posedge clock) disable iff (!rst_n)
    por_rise |=> (boot_q == $past(boot_config_pins)))
    else $error("boot pins not captured");
endmodule // reset_sequencer_error_pin

// [rtl/rst_seq_pkg.sv]
/*
  constants shared by the reset sequencer and its error pin unit.
  assumes one 100 MHz clock standing in for both the main oscillator and the
  error-module functional clock.
*/
package rst_seq_pkg;
  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int MCU_STAT_PERIODS   = 6120;
  localparam int MAIN_STAT_PERIODS  = 9195;
  localparam int SW_MCU_PERIODS     = 966;
  localparam int SW_MAIN_PERIODS    = 4040;
  localparam int POR_OUT_DELAY_NS   = 1840;
  localparam int POR_OUT_WIDTH_NS   = 1200;
  localparam int POR_OUT_DELAY_CYC  = (POR_OUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_OUT_WIDTH_CYC  = (POR_OUT_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERR_DELAY_PERIODS  = 50;
  localparam int CNT_W              = 16;
  localparam int BOOT_W             = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] ERR_DELAY_CNT = CNT_W'(ERR_DELAY_PERIODS);
  localparam logic [BOOT_W-1:0] BOOT_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ERR_IDLE  = 3'b001,
    ERR_DELAY = 3'b010,
    ERR_ACT   = 3'b100
  } err_state_t;
endpackage

// [rtl/err_pin_if.sv]
/*
  carrier between the sequencer top and its error pin unit.
  assumes both ends run on the same clock.
*/
interface err_pin_if;
  logic                            err_event;
  logic                            err_clear;
  logic                            pwm_en;
  logic [rst_seq_pkg::CNT_W-1:0]   pulse_preload;
  logic [rst_seq_pkg::CNT_W-1:0]   high_preload;
  logic [rst_seq_pkg::CNT_W-1:0]   low_preload;
  logic                            pin_n;
  logic                            err_active;
  modport ctrl (output err_event, err_clear, pwm_en, pulse_preload, high_preload,
                low_preload, input pin_n, err_active);
  modport pin  (input err_event, err_clear, pwm_en, pulse_preload, high_preload,
                low_preload, output pin_n, err_active);
endinterface

// [rtl/err_pin_unit.sv]
/*
  error pin driver: delay, timed low pulse or pwm with freeze on error.
  assumes preloads held stable while in use and nonzero.
*/
module err_pin_unit (
  input wire logic clock,
  input wire logic rst_n,
  err_pin_if.pin   bus
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  rst_seq_pkg::err_state_t         st_q, st_d;
  logic [rst_seq_pkg::CNT_W-1:0]   cnt_q, cnt_d;
  logic [rst_seq_pkg::CNT_W-1:0]   pwm_q, pwm_d;
  logic                            pin_q, pin_d;

  wire cnt_done = (cnt_q == rst_seq_pkg::CNT_ONE);
  wire pwm_done = (pwm_q == rst_seq_pkg::CNT_ONE);
  wire [rst_seq_pkg::CNT_W-1:0] next_seg = pin_q ? bus.low_preload : bus.high_preload;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    pwm_d  = pwm_q;
    pin_d  = pin_q;
    // pwm toggles whenever enabled and not in ERR_ACT, through the delay too
    if (bus.pwm_en && st_q != rst_seq_pkg::ERR_ACT) begin
      if (pwm_done || pwm_q == rst_seq_pkg::CNT_ZERO) begin
        pin_d = ~pin_q;
        pwm_d = next_seg;
      end else begin
        pwm_d = pwm_q - rst_seq_pkg::CNT_ONE;
      end
    end else if (!bus.pwm_en && st_q != rst_seq_pkg::ERR_ACT) begin
      pin_d = 1'b1;
      pwm_d = rst_seq_pkg::CNT_ZERO;
    end
    case (st_q)
      rst_seq_pkg::ERR_IDLE: begin
        if (bus.err_event) begin
          st_d  = rst_seq_pkg::ERR_DELAY;
          cnt_d = rst_seq_pkg::ERR_DELAY_CNT;
        end
      end
      rst_seq_pkg::ERR_DELAY: begin
        if (cnt_done) begin
          st_d  = rst_seq_pkg::ERR_ACT;
          cnt_d = bus.pulse_preload;
          if (!bus.pwm_en) begin
            pin_d = 1'b0; // active low pulse
          end
        end else begin
          cnt_d = cnt_q - rst_seq_pkg::CNT_ONE;
        end
      end
      rst_seq_pkg::ERR_ACT: begin
        // pwm level frozen here until cleared
        if (cnt_q != rst_seq_pkg::CNT_ZERO) begin
          cnt_d = cnt_q - rst_seq_pkg::CNT_ONE;
        end
        if (bus.err_clear && (bus.pwm_en || cnt_q <= rst_seq_pkg::CNT_ONE)) begin
          st_d = rst_seq_pkg::ERR_IDLE; // pulse never cut short
          if (!bus.pwm_en) begin
            pin_d = 1'b1;
          end
        end
      end
      default: st_d = rst_seq_pkg::ERR_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= rst_seq_pkg::ERR_IDLE;
      cnt_q  <= rst_seq_pkg::CNT_ZERO;
      pwm_q  <= rst_seq_pkg::CNT_ZERO;
      pin_q  <= 1'b1;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      pwm_q  <= pwm_d;
      pin_q  <= pin_d;
    end
  end

  assign bus.pin_n      = pin_q;
  assign bus.err_active = (st_q == rst_seq_pkg::ERR_ACT);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_ERR_DELAY: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q == rst_seq_pkg::ERR_IDLE && bus.err_event)
      |=> (!bus.err_active [*8]) ##42 !bus.err_active ##1 bus.err_active)
    else $error("error output active too early");
  AST_PWM_FREEZE: assert property (@(posedge clock) disable iff (!rst_n)
    (bus.err_active && bus.pwm_en && $past(bus.err_active)) |-> $stable(pin_q))
    else $error("pwm toggled after error");
  AST_PULSE_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    (bus.err_active && !bus.pwm_en && $past(bus.err_active) && !$past(bus.pwm_en))
      |-> !pin_q)
    else $error("error pulse not low");
endmodule // err_pin_unit

// [test/board_supervisor_model.sv]
/*
  board supervisor model: power-on reset, warm reset and boot pins.
  assumes its tasks are called off the rising clock edge.
*/
module board_supervisor_model #(
  parameter int POR_MIN_CYC  = 120,
  parameter int WARM_MIN_CYC = 120,
  parameter int XTAL_MIN_CYC = 950000,
  parameter bit CRYSTAL      = 1'b0
) (
  input  wire logic                           clock,
  input  wire logic                           main_por_out_n,
  input  wire logic [rst_seq_pkg::BOOT_W-1:0] boot_value,
  output logic                                power_on_reset_in_n,
  output logic                                mcu_warm_reset_in_n,
  output logic [rst_seq_pkg::BOOT_W-1:0]      boot_config_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------
  // reset pins
  // -------------------------
  int low_cyc = 0;
  bit powered = 1'b0;
  // crystal start-up hold is far beyond the run budget, so the bench picks a clock source
  localparam int FIRST_MIN_CYC = CRYSTAL ? XTAL_MIN_CYC : POR_MIN_CYC;
  // rails stay valid all run: none drops, so no decay wait nor partial-pin step
  initial begin
    power_on_reset_in_n = 1'b0;
    mcu_warm_reset_in_n = 1'b1;
    boot_config_pins    = 16'h0000;
  end
  // external clock source, so the short hold applies from time zero
  always @(posedge clock) low_cyc <= power_on_reset_in_n ? 0 : low_cyc + 1;
  task automatic por_low();
    @(negedge clock);
    power_on_reset_in_n = 1'b0;
  endtask
  task automatic por_high();
    @(negedge clock);
    while (low_cyc < (powered ? POR_MIN_CYC : FIRST_MIN_CYC)) @(negedge clock);
    powered = 1'b1;
    power_on_reset_in_n = 1'b1;
  endtask
  // only used once the power-on reset has finished
  task automatic warm_pulse();
    @(negedge clock);
    mcu_warm_reset_in_n = 1'b0;
    repeat (WARM_MIN_CYC) @(negedge clock);
    mcu_warm_reset_in_n = 1'b1;
  endtask
  // -------------------------
  // boot pins
  // -------------------------
  // held while the main por output is low, scrambled once its hold ran out
  always @(negedge clock)
    boot_config_pins <= (main_por_out_n === 1'b1) ? ~boot_config_pins : boot_value;
endmodule // board_supervisor_model

// [test/reset_sequencer_error_pin_tb.sv]
/*
  self-checking bench for the reset sequencer and safety error pin.
  assumes the board model drives reset and boot pins.
*/
module reset_sequencer_error_pin_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           clock = 1'b0;
  logic                           rst_n, power_on_reset_in_n, mcu_warm_reset_in_n;
  logic                           sw_mcu_domain_warm_reset, sw_main_power_on_reset;
  logic                           sw_main_domain_warm_reset, error_event, error_clear;
  logic                           pwm_mode_en, mcu_domain_reset_status_n, lvl;
  logic                           main_domain_reset_status_n, main_por_out_n;
  logic                           safety_error_out_n, error_active;
  logic [rst_seq_pkg::BOOT_W-1:0] boot_config_pins, boot_config_latched, boot_value;
  logic [rst_seq_pkg::CNT_W-1:0]  pin_counter_preload, pwm_high_preload, pwm_low_preload;
  logic [31:0]                    lfsr_q = 32'h0B5F;
  logic [31:0]                    r;
  int                             fails = 0, n_compared = 0, n, n0, n1;
  reset_sequencer_error_pin reset_sequencer_error_pin_i (.clock, .rst_n, .power_on_reset_in_n,
    .mcu_warm_reset_in_n, .sw_mcu_domain_warm_reset, .sw_main_power_on_reset,
    .sw_main_domain_warm_reset, .boot_config_pins, .error_event, .error_clear, .pwm_mode_en,
    .pin_counter_preload, .pwm_high_preload, .pwm_low_preload, .mcu_domain_reset_status_n,
    .main_domain_reset_status_n, .main_por_out_n, .boot_config_latched, .safety_error_out_n,
    .error_active);
  board_supervisor_model board_supervisor_model_i (.clock, .main_por_out_n, .boot_value,
    .power_on_reset_in_n, .mcu_warm_reset_in_n, .boot_config_pins);
  always #5 clock = ~clock;
  // -------------------------
  // helpers
  // -------------------------
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  function automatic logic outsel(int s);
    case (s)
      0: return mcu_domain_reset_status_n;
      1: return main_domain_reset_status_n;
      2: return main_por_out_n;
      3: return safety_error_out_n;
      default: return error_active;
    endcase
  endfunction
  task automatic check(input logic ok, input string what);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic count_to(int s, logic v, int limit, output int c);
    c = 0;
    while (outsel(s) !== v && c < limit) begin
      @(negedge clock);
      c++;
    end
    check(c < limit, "level never reached");
  endtask
  // times one low phase against a window of cycles
  task automatic span(int s, int lo, int hi, string what);
    int c;
    count_to(s, 1'b0, 8, c);
    count_to(s, 1'b1, hi + 2, c);
    check(c >= lo && c <= hi, what);
  endtask
  task automatic rise(int s, int lo, string what);
    int c;
    count_to(s, 1'b1, lo + 6, c);
    check(c >= lo && c <= lo + 3, what);
  endtask
  task automatic drive(int k);
    @(negedge clock);
    sw_mcu_domain_warm_reset = (k == 0);
    sw_main_power_on_reset = (k == 1);
    sw_main_domain_warm_reset = (k == 2);
    if (k == 3) board_supervisor_model_i.warm_pulse();
    @(negedge clock);
    {sw_mcu_domain_warm_reset, sw_main_power_on_reset, sw_main_domain_warm_reset} = 3'h0;
  endtask
  task automatic end_of_test();
    $display("compared %0d, failures %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // -------------------------
  // watchdog
  // -------------------------
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    end_of_test();
  end
  // -------------------------
  // main sequence
  // -------------------------
  initial begin
    rst_n = 1'b0;
    {sw_mcu_domain_warm_reset, sw_main_power_on_reset, sw_main_domain_warm_reset} = 3'h0;
    {error_event, error_clear, pwm_mode_en} = 3'h0;
    {pin_counter_preload, pwm_high_preload, pwm_low_preload} = {3{16'h0002}};
    boot_value = 16'hA5C3;
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        r = rnd();
        boot_value = r[15:0];
        board_supervisor_model_i.por_low();
        #1;
      end
      check({mcu_domain_reset_status_n, main_domain_reset_status_n, main_por_out_n} === 3'h0, "outputs not low under por");
      board_supervisor_model_i.por_high();
      fork
        rise(2, rst_seq_pkg::POR_OUT_DELAY_CYC, "main por out release");
        rise(0, rst_seq_pkg::MCU_STAT_PERIODS, "mcu status release");
        rise(1, rst_seq_pkg::MAIN_STAT_PERIODS, "main status release");
      join
      check(boot_config_latched === boot_value, "boot capture");
    end
    // software resets (mcu warm, main por, main warm) and pin warm reset, one source at a time
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      boot_value = r[15:0];
      fork
        drive(k);
        if (k == 0 || k == 3) span(0, rst_seq_pkg::SW_MCU_PERIODS, rst_seq_pkg::SW_MCU_PERIODS + (k == 3 ? 124 : 3), "mcu status width");
        span(1, rst_seq_pkg::SW_MAIN_PERIODS, rst_seq_pkg::SW_MAIN_PERIODS + (k == 3 ? 124 : 3), "main status width");
        if (k == 1) span(2, rst_seq_pkg::POR_OUT_WIDTH_CYC, rst_seq_pkg::POR_OUT_WIDTH_CYC + 3, "por out width");
      join
      if (k == 1) check(boot_config_latched === boot_value, "boot capture after sw por");
    end
    // timed low pulse, shortest preload first
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      pin_counter_preload = 16'(i == 0 ? 1 : r[4:0] + 2);
      @(negedge clock);
      error_event = 1'b1;
      @(negedge clock);
      error_event = 1'b0;
      count_to(3, 1'b0, 60, n);
      check(n >= rst_seq_pkg::ERR_DELAY_PERIODS && n <= rst_seq_pkg::ERR_DELAY_PERIODS + 2, "error delay");
      check(error_active === 1'b1, "error not active");
      error_clear = 1'b1;
      count_to(3, 1'b1, int'(pin_counter_preload) + 8, n);
      error_clear = 1'b0;
      check(n >= int'(pin_counter_preload) && n <= int'(pin_counter_preload) + 3, "pulse width");
      @(negedge clock);
      check(error_active === 1'b0, "error not cleared");
    end
    // pwm waveform, then freeze on error
    r = rnd();
    pwm_high_preload = 16'(r[3:0] + 2);
    pwm_low_preload = 16'(r[7:4] + 2);
    pwm_mode_en = 1'b1;
    count_to(3, 1'b0, 40, n);
    count_to(3, 1'b1, 40, n);
    count_to(3, 1'b0, 40, n0);
    count_to(3, 1'b1, 40, n1);
    check(n0 + n1 === int'(pwm_high_preload) + int'(pwm_low_preload), "pwm period");
    @(negedge clock);
    error_event = 1'b1;
    @(negedge clock);
    error_event = 1'b0;
    repeat (55) @(negedge clock);
    lvl = safety_error_out_n;
    n = 0;
    repeat (40) begin
      @(negedge clock);
      if (safety_error_out_n !== lvl) n++;
    end
    check(n == 0 && error_active === 1'b1, "pwm not frozen");
    error_clear = 1'b1;
    @(negedge clock);
    error_clear = 1'b0;
    count_to(3, ~lvl, 40, n);
    pwm_mode_en = 1'b0;
    repeat (10) @(negedge clock);
    end_of_test();
  end
endmodule // reset_sequencer_error_pin_tb
